// >>> fwp_pkg.sv
package fwp_pkg;

  // Command opcodes seen on the serial link.
  localparam logic [7:0] CMD_WR_ENABLE      = 8'h06;
  localparam logic [7:0] CMD_WR_DISABLE     = 8'h04;
  localparam logic [7:0] CMD_STATUS_WRITE   = 8'h01;
  localparam logic [7:0] CMD_SPECIAL_WRITE  = 8'h42;
  localparam logic [7:0] CMD_ANY_REG_WRITE  = 8'h71;
  localparam logic [7:0] CMD_SERIAL_WRITE   = 8'hc2;
  localparam logic [7:0] CMD_MEM_WRITE      = 8'h02;
  localparam logic [7:0] CMD_STATUS1_READ   = 8'h05;
  localparam logic [7:0] CMD_STATUS2_READ   = 8'h07;
  localparam logic [7:0] CMD_ANY_REG_READ   = 8'h65;
  localparam logic [7:0] CMD_CRC_CALC       = 8'h5b;
  localparam logic [7:0] CMD_CRC_SUSPEND    = 8'h75;
  localparam logic [7:0] CMD_CRC_RESUME     = 8'h7a;
  localparam logic [7:0] CMD_RESET_ENABLE   = 8'h66;
  localparam logic [7:0] CMD_RESET          = 8'h99;

  // Register addresses used by the any-register commands.
  localparam logic [23:0] ADDR_STATUS1_NV   = 24'h000000;
  localparam logic [23:0] ADDR_STATUS1_V    = 24'h070000;
  localparam logic [23:0] ADDR_STATUS2_NV   = 24'h000001;
  localparam logic [23:0] ADDR_STATUS2_V    = 24'h070001;

  // Field layout, masks and reset values.
  localparam int          POS_CRC_SUSPENDED = 4;
  localparam int          POS_CRC_ABORTED   = 3;
  localparam logic [7:0]  STATUS1_WR_MASK   = 8'hbc;
  localparam logic [7:0]  STATUS1_RESET     = 8'h00;
  localparam logic [7:0]  STATUS2_RESET     = 8'h00;

  // Array geometry and command framing.
  localparam int          ARRAY_AW          = 19;
  localparam logic [4:0]  PROT_BASE_LOG     = 5'h0c;
  localparam logic [2:0]  ADDR_BYTES        = 3'h3;
  localparam logic [2:0]  CRC_ADDR_BYTES    = 3'h6;
  localparam logic [2:0]  LAST_BIT          = 3'h7;
  localparam logic [24:0] CRC_MIN_SPAN      = 25'h0000003;

  typedef struct packed {
    logic       register_write_lock;
    logic       reserved;
    logic       protect_from_bottom;
    logic [2:0] block_protect;
    logic       write_enable_latch;
    logic       busy_flag;
  } fwp_status_one_t;

  typedef struct packed {
    logic                en;
    logic [ARRAY_AW-1:0] addr;
    logic [7:0]          data;
  } fwp_mem_wr_t;

  typedef struct packed {
    logic        start;
    logic [23:0] start_address;
    logic [23:0] end_address;
  } fwp_crc_req_t;

endpackage

// >>> fwp_sync3.sv
`timescale 1ns/100ps
module fwp_sync3 #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset.
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  // Raw inputs from outside the clock domain.
  input  wire logic [W-1:0] async_in,
  // Filtered level and one-cycle edge pulses.
  output logic [W-1:0]      level_out,
  output logic [W-1:0]      rise_out,
  output logic [W-1:0]      fall_out
);

  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, rise_q, fall_q;
  logic [W-1:0] lvl_d;

  // A bit changes only once the second and third stages agree.
  always_comb begin
    lvl_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
  end

  // Three stages, the filtered level and its edges.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_q   <= RST;
      s2_q   <= RST;
      s3_q   <= RST;
      lvl_q  <= RST;
      rise_q <= '0;
      fall_q <= '0;
    end else begin
      s1_q   <= async_in;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_q  <= lvl_d;
      rise_q <= lvl_d & ~lvl_q;
      fall_q <= ~lvl_d & lvl_q;
    end
  end

  assign level_out = lvl_q;
  assign rise_out  = rise_q;
  assign fall_out  = fall_q;

endmodule

// >>> fwp_prot_dec.sv
`timescale 1ns/100ps
module fwp_prot_dec
  import fwp_pkg::*;
(
  // Protection settings.
  input  wire logic [2:0]          block_protect_in,
  input  wire logic                protect_from_bottom_in,
  // Address under test.
  input  wire logic [ARRAY_AW-1:0] addr_in,
  output logic                     protected_out
);

  logic [ARRAY_AW-1:0] hi_mask;
  logic [ARRAY_AW-1:0] masked;

  // For codes 1-7 the protected span is 2 to the power (base + code); code 7 spans the array, code 0 protects nothing.
  always_comb begin
    hi_mask = {ARRAY_AW{1'b1}} << (PROT_BASE_LOG + {2'h0, block_protect_in});
    masked  = addr_in & hi_mask;
    if (block_protect_in == 3'h0) begin
      protected_out = 1'b0;
    end else if (protect_from_bottom_in) begin
      protected_out = (masked == '0); // [R2]
    end else begin
      protected_out = (masked == hi_mask); // [R1]
    end
  end

endmodule

// >>> fwp_core.sv
`timescale 1ns/100ps
// Functional notes
// [R1] Select 0: codes 1-6 protect top 1/64..1/2 of array, code 7 everything.
// [R2] Select 1: codes 1-6 protect bottom 1/64..1/2, code 7 all, 0 none.
// [R3] Memory writes inside the protected range are refused, locations unchanged.
// [R4] Array and register writes need the write enable latch at 1.
// [R5] Only the write enable command sets the latch.
// [R6] Disable, status, special, any-register, serial writes clear latch at chip-select rise.
// [R7] Memory array writes leave the latch set.
// [R8] Latch clears on power-on and every other reset.
// [R9] Registers locked only when lock bit is 1 and protect pin low.
// [R10] Lock covers writable bits only; read-only and reserved bits excluded.
// [R11] Busy flag is 1 only while a CRC calculation runs.
// [R12] While busy only status reads, CRC suspend and reset sequence are accepted.
// [R13] Host must not poll busy flag during power-up or reset.
// [R14] Busy flag clears on every reset.
// [R15] Second status register is read-only, read by its opcode or any-register read.
// [R16] CRC suspend during a calculation sets the suspended flag, bit 4.
// [R17] CRC resume clears the suspended flag.
// [R18] Suspended flag clears on power-on, hardware and software reset.
// [R19] CRC command aborts and sets bit 3 when end below start plus 3.
// [R20] Abort flag clears on a successful CRC start and on all resets.
// [R21] Status reads return the volatile copy.
// [R22] Power-up or hardware reset copies nonvolatile settings into the volatile copy.
// [R23] Reserved bits of the second status register read as 0.
module fwp_core
  import fwp_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  // Serial link pins.
  input  wire logic        spi_sck_in,
  input  wire logic        spi_cs_n_in,
  input  wire logic        spi_si_in,
  input  wire logic        write_protect_n_in,
  output logic             spi_so_out,
  output logic             spi_so_oe_n_out,
  // Nonvolatile copy of the first status register.
  input  wire logic [7:0]  nv_status_one_in,
  output logic             nv_status_one_wr_out,
  output logic [7:0]       nv_status_one_data_out,
  // Array write port.
  output fwp_mem_wr_t      mem_wr_out,
  // CRC engine handshake.
  output fwp_crc_req_t     crc_req_out,
  output logic             crc_suspend_out,
  input  wire logic        crc_done_in,
  // Volatile status for observation.
  output logic [7:0]       status_one_out,
  output logic [7:0]       status_two_out
);

  typedef enum logic [1:0] {ST_OPCODE, ST_ADDR, ST_DATA, ST_SKIP} fwp_state_t;

  ////////////////////////////////////////////////////////////////////////////////

  // Sync outputs; bit order is write protect, data in, chip select, clock.
  logic [3:0] pin_lvl, pin_rise, pin_fall;
  logic       sck_rise, sck_fall, cs_lvl, cs_rise, si_lvl, wp_lvl;
  logic       addr_prot;

  fwp_state_t      st_q, st_d;
  logic [2:0]      bit_q, bit_d, byte_q, byte_d;
  logic [7:0]      shift_q, shift_d, op_q, op_d, data_q, data_d, tx_q, tx_d;
  logic [47:0]     addr_q, addr_d;
  logic            seen_q, seen_d, rd_q, rd_d, so_q, so_d, oe_n_q, oe_n_d;
  logic            load_q, load_d, armed_q, armed_d, nvwr_q, nvwr_d;
  logic [7:0]      nvdata_q, nvdata_d, sr2_q, sr2_d;
  fwp_status_one_t sr1_q, sr1_d;
  fwp_mem_wr_t     mem_q, mem_d;
  fwp_crc_req_t    crc_q, crc_d;
  logic [7:0]      nbit;
  logic [47:0]     naddr;
  logic [2:0]      need;
  logic            reg_wr_ok;

  // Pins from outside pass the three-stage filter; chip select idles high.
  fwp_sync3 #(
    .W   (4),
    .RST (4'h2)
  ) u_sync (
    .clk_in    (clk_sys_in),
    .nrst_in   (nrst_in),
    .async_in  ({write_protect_n_in, spi_si_in, spi_cs_n_in, spi_sck_in}),
    .level_out (pin_lvl),
    .rise_out  (pin_rise),
    .fall_out  (pin_fall)
  );

  assign sck_rise = pin_rise[0];
  assign sck_fall = pin_fall[0];
  assign cs_lvl   = pin_lvl[1];
  assign cs_rise  = pin_rise[1];
  assign si_lvl   = pin_lvl[2];
  assign wp_lvl   = pin_lvl[3];

  // Range check on the address of the current array write byte.
  fwp_prot_dec u_prot (
    .block_protect_in       (sr1_q.block_protect),
    .protect_from_bottom_in (sr1_q.protect_from_bottom),
    .addr_in                (addr_q[ARRAY_AW-1:0]),
    .protected_out          (addr_prot)
  );

  ////////////////////////////////////////////////////////////////////////////////

  // Loads only the writable bits; read-only and reserved bits keep their value.
  function automatic fwp_status_one_t merge_one(input fwp_status_one_t cur,
                                                input logic [7:0] val);
    merge_one = fwp_status_one_t'((cur & ~STATUS1_WR_MASK) | (val & STATUS1_WR_MASK)); // [R10]
  endfunction

  // True for either address of the second status register.
  function automatic logic is_status_two(input logic [23:0] a);
    is_status_two = (a == ADDR_STATUS2_NV) || (a == ADDR_STATUS2_V);
  endfunction

  // True for any status register address.
  function automatic logic is_status(input logic [23:0] a);
    is_status = is_status_two(a) || (a == ADDR_STATUS1_NV) || (a == ADDR_STATUS1_V);
  endfunction

  // Opcodes that may start while a calculation is running.
  function automatic logic busy_ok(input logic [7:0] op);
    busy_ok = (op == CMD_STATUS1_READ) || (op == CMD_STATUS2_READ) ||
              (op == CMD_ANY_REG_READ) || (op == CMD_CRC_SUSPEND) ||
              (op == CMD_RESET_ENABLE) || (op == CMD_RESET);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  // Register writes need the latch and no lock from the lock bit with the pin low.
  assign reg_wr_ok = sr1_q.write_enable_latch &&
                     !(sr1_q.register_write_lock && !wp_lvl); // [R4] [R9]

  // Command decoder, status registers and output shifting.
  always_comb begin
    st_d         = st_q;
    bit_d        = bit_q;
    byte_d       = byte_q;
    shift_d      = shift_q;
    op_d         = op_q;
    addr_d       = addr_q;
    data_d       = data_q;
    seen_d       = seen_q;
    rd_d         = rd_q;
    tx_d         = tx_q;
    so_d         = so_q;
    oe_n_d       = oe_n_q;
    sr1_d        = sr1_q;
    sr2_d        = sr2_q;
    load_d       = 1'b0;
    armed_d      = armed_q;
    nvwr_d       = 1'b0;
    nvdata_d     = nvdata_q;
    mem_d        = mem_q;
    mem_d.en     = 1'b0;
    crc_d        = crc_q;
    crc_d.start  = 1'b0;
    nbit         = {shift_q[6:0], si_lvl};
    naddr        = {addr_q[39:0], nbit};
    need         = (op_q == CMD_CRC_CALC) ? CRC_ADDR_BYTES : ADDR_BYTES;

    // First cycle after hardware reset takes the nonvolatile settings.
    if (load_q) begin
      sr1_d = merge_one(sr1_q, nv_status_one_in); // [R22]
    end

    // Busy ends when the engine reports completion.
    if (crc_done_in && sr1_q.busy_flag) begin
      sr1_d.busy_flag = 1'b0; // [R11]
    end

    // Input bits are taken on clock rises while selected.
    if (!cs_lvl && sck_rise) begin
      shift_d = nbit;
      bit_d   = bit_q + 3'h1;
      if (bit_q == LAST_BIT) begin
        case (st_q)
          ST_OPCODE: begin
            op_d   = nbit;
            byte_d = 3'h0;
            if (sr1_q.busy_flag && !busy_ok(nbit)) begin
              st_d = ST_SKIP; // [R12]
            end else if (nbit == CMD_STATUS1_READ) begin
              tx_d = sr1_q; // [R21]
              rd_d = 1'b1;
              st_d = ST_DATA;
            end else if (nbit == CMD_STATUS2_READ) begin
              tx_d = sr2_q; // [R15]
              rd_d = 1'b1;
              st_d = ST_DATA;
            end else if ((nbit == CMD_MEM_WRITE) || (nbit == CMD_ANY_REG_READ) ||
                         (nbit == CMD_ANY_REG_WRITE) || (nbit == CMD_CRC_CALC)) begin
              st_d = ST_ADDR;
            end else begin
              st_d = ST_DATA;
            end
          end
          ST_ADDR: begin
            addr_d = naddr;
            byte_d = byte_q + 3'h1;
            if (byte_q == need - 3'h1) begin
              st_d = ST_DATA;
              if (op_q == CMD_ANY_REG_READ) begin
                rd_d = 1'b1;
                if (sr1_q.busy_flag && !is_status(naddr[23:0])) begin
                  st_d = ST_SKIP; // [R12]
                  rd_d = 1'b0;
                end else if (is_status_two(naddr[23:0])) begin
                  tx_d = sr2_q; // [R15]
                end else if (is_status(naddr[23:0])) begin
                  tx_d = sr1_q; // [R21]
                end else begin
                  tx_d = 8'h00;
                end
              end
            end
          end
          ST_DATA: begin
            data_d = nbit;
            seen_d = 1'b1;
            // Reads repeat the same register on every following byte.
            if (op_q == CMD_STATUS1_READ) begin
              tx_d = sr1_q;
            end else if (op_q == CMD_STATUS2_READ) begin
              tx_d = sr2_q;
            end else if (op_q == CMD_ANY_REG_READ) begin
              tx_d = is_status_two(addr_q[23:0]) ? sr2_q :
                     is_status(addr_q[23:0]) ? sr1_q : 8'h00;
            end else if (op_q == CMD_MEM_WRITE) begin
              // Unwritable bytes are dropped; the address still advances.
              if (sr1_q.write_enable_latch && !addr_prot) begin // [R3] [R4]
                mem_d.en   = 1'b1;
                mem_d.addr = addr_q[ARRAY_AW-1:0];
                mem_d.data = nbit;
              end
              addr_d[ARRAY_AW-1:0] = addr_q[ARRAY_AW-1:0] + {{(ARRAY_AW-1){1'b0}}, 1'b1};
            end
          end
          ST_SKIP: begin
            st_d = ST_SKIP;
          end
          default: begin
            st_d = ST_SKIP;
          end
        endcase
      end
    end

    // Read data moves out on clock falls.
    if (!cs_lvl && sck_fall) begin
      so_d   = tx_q[7];
      tx_d   = {tx_q[6:0], 1'b0};
      oe_n_d = ~rd_q;
    end

    // Deselect ends the command; whole-byte commands take effect here.
    if (cs_rise) begin
      armed_d = 1'b0;
      if ((st_q != ST_OPCODE) && (st_q != ST_SKIP) && (bit_q == 3'h0)) begin
        case (op_q)
          CMD_WR_ENABLE: begin
            sr1_d.write_enable_latch = 1'b1; // [R5]
          end
          CMD_WR_DISABLE, CMD_SPECIAL_WRITE, CMD_SERIAL_WRITE: begin
            sr1_d.write_enable_latch = 1'b0; // [R6]
          end
          CMD_STATUS_WRITE: begin
            if (seen_q && reg_wr_ok) begin
              sr1_d    = merge_one(sr1_q, data_q); // [R9]
              nvwr_d   = 1'b1;
              nvdata_d = data_q & STATUS1_WR_MASK;
            end
            sr1_d.write_enable_latch = 1'b0; // [R6]
          end
          CMD_ANY_REG_WRITE: begin
            if ((st_q == ST_DATA) && seen_q && reg_wr_ok) begin
              if (addr_q[23:0] == ADDR_STATUS1_NV) begin
                sr1_d    = merge_one(sr1_q, data_q); // [R9]
                nvwr_d   = 1'b1;
                nvdata_d = data_q & STATUS1_WR_MASK;
              end else if (addr_q[23:0] == ADDR_STATUS1_V) begin
                sr1_d = merge_one(sr1_q, data_q); // [R9]
              end
            end
            sr1_d.write_enable_latch = 1'b0; // [R6]
          end
          CMD_MEM_WRITE: begin
            sr1_d.write_enable_latch = sr1_q.write_enable_latch; // [R7]
          end
          CMD_CRC_CALC: begin
            if ({1'b0, addr_q[23:0]} < ({1'b0, addr_q[47:24]} + CRC_MIN_SPAN)) begin
              sr2_d[POS_CRC_ABORTED] = 1'b1; // [R19]
            end else begin
              sr2_d[POS_CRC_ABORTED] = 1'b0; // [R20]
              crc_d.start            = 1'b1;
              crc_d.start_address    = addr_q[47:24];
              crc_d.end_address      = addr_q[23:0];
              sr1_d.busy_flag        = 1'b1; // [R11]
            end
          end
          CMD_CRC_SUSPEND: begin
            if (sr1_q.busy_flag) begin
              sr2_d[POS_CRC_SUSPENDED] = 1'b1; // [R16]
              sr1_d.busy_flag          = 1'b0; // [R11]
            end
          end
          CMD_CRC_RESUME: begin
            if (sr2_q[POS_CRC_SUSPENDED]) begin
              sr2_d[POS_CRC_SUSPENDED] = 1'b0; // [R17]
              sr1_d.busy_flag          = 1'b1;
            end
          end
          CMD_RESET_ENABLE: begin
            armed_d = 1'b1;
          end
          CMD_RESET: begin
            // Software reset clears the volatile flags; protection settings stay.
            if (armed_q) begin
              sr1_d.write_enable_latch = 1'b0; // [R8]
              sr1_d.busy_flag          = 1'b0; // [R14]
              sr2_d                    = STATUS2_RESET; // [R18] [R20]
            end
          end
          default: begin
            armed_d = 1'b0;
          end
        endcase
      end
      st_d   = ST_OPCODE;
      bit_d  = 3'h0;
      byte_d = 3'h0;
      seen_d = 1'b0;
      rd_d   = 1'b0;
      so_d   = 1'b0;
      oe_n_d = 1'b1;
    end
    sr2_d = sr2_d & ((8'h01 << POS_CRC_SUSPENDED) | (8'h01 << POS_CRC_ABORTED)); // [R23]
  end

  // State registers; all volatile flags return to zero on hardware reset.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q     <= ST_OPCODE;
      bit_q    <= 3'h0;
      byte_q   <= 3'h0;
      shift_q  <= 8'h00;
      op_q     <= 8'h00;
      addr_q   <= '0;
      data_q   <= 8'h00;
      seen_q   <= 1'b0;
      rd_q     <= 1'b0;
      tx_q     <= 8'h00;
      so_q     <= 1'b0;
      oe_n_q   <= 1'b1;
      sr1_q    <= fwp_status_one_t'(STATUS1_RESET); // [R8] [R14]
      sr2_q    <= STATUS2_RESET; // [R18] [R20]
      load_q   <= 1'b1;
      armed_q  <= 1'b0;
      nvwr_q   <= 1'b0;
      nvdata_q <= 8'h00;
      mem_q    <= '0;
      crc_q    <= '0;
    end else begin
      st_q     <= st_d;
      bit_q    <= bit_d;
      byte_q   <= byte_d;
      shift_q  <= shift_d;
      op_q     <= op_d;
      addr_q   <= addr_d;
      data_q   <= data_d;
      seen_q   <= seen_d;
      rd_q     <= rd_d;
      tx_q     <= tx_d;
      so_q     <= so_d;
      oe_n_q   <= oe_n_d;
      sr1_q    <= sr1_d;
      sr2_q    <= sr2_d;
      load_q   <= load_d;
      armed_q  <= armed_d;
      nvwr_q   <= nvwr_d;
      nvdata_q <= nvdata_d;
      mem_q    <= mem_d;
      crc_q    <= crc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Outputs straight from flip-flops.
  assign spi_so_out             = so_q;
  assign spi_so_oe_n_out        = oe_n_q;
  assign nv_status_one_wr_out   = nvwr_q;
  assign nv_status_one_data_out = nvdata_q;
  assign mem_wr_out             = mem_q;
  assign crc_req_out            = crc_q;
  assign crc_suspend_out        = sr2_q[POS_CRC_SUSPENDED];
  assign status_one_out         = sr1_q;
  assign status_two_out         = sr2_q;

endmodule

// >>> fwp_core_sva.sv
`timescale 1ns/100ps
module fwp_core_sva
  import fwp_pkg::*;
(
  // Clock and reset.
  input wire logic         clk_sys_in,
  input wire logic         nrst_in,
  // Watched outputs and the CRC done input.
  input wire fwp_mem_wr_t  mem_wr_out,
  input wire fwp_crc_req_t crc_req_out,
  input wire logic         crc_suspend_out,
  input wire logic         crc_done_in,
  input wire logic         nv_status_one_wr_out,
  input wire logic [7:0]   nv_status_one_data_out,
  input wire logic [7:0]   status_one_out,
  input wire logic [7:0]   status_two_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  // Protected span and whether the written byte is inside it.
  logic [19:0] span;
  logic        in_prot;
  assign span    = 20'h01000 << status_one_out[4:2];
  assign in_prot = (status_one_out[4:2] == 3'h7) || ((status_one_out[4:2] != 3'h0) &&
    (status_one_out[5] ? ({1'b0, mem_wr_out.addr} < span)
                       : ({1'b0, mem_wr_out.addr} >= 20'h80000 - span)));

  ////////////////////////////////////////////////////////////////////////////////
  chk_prot_refuse: assert property (mem_wr_out.en |-> !in_prot)
    else $error("Array write landed in a protected range.");
  chk_wel_write: assert property (mem_wr_out.en |->
    status_one_out[1] ##1 status_one_out[1])
    else $error("Latch missing at or after an array write.");
  chk_busy_done: assert property (status_one_out[0] && crc_done_in |->
    ##[1:2] !status_one_out[0])
    else $error("Busy flag stayed up after the CRC finished.");
  chk_busy_cause: assert property ($rose(status_one_out[0]) |->
    crc_req_out.start || $past(crc_req_out.start) || $past(status_two_out[4]))
    else $error("Busy flag rose without a CRC start or resume.");
  chk_start_span: assert property (crc_req_out.start |->
    {1'b0, crc_req_out.end_address} >= {1'b0, crc_req_out.start_address} + CRC_MIN_SPAN)
    else $error("CRC started with too short a range.");
  chk_abort_clear: assert property (crc_req_out.start |->
    ##[0:1] (!status_two_out[3] && status_one_out[0]))
    else $error("CRC start left the abort flag set or busy low.");
  chk_susp_level: assert property ($rose(crc_suspend_out) |-> $past(status_one_out[0]))
    else $error("Suspend output rose with no CRC running.");
  chk_susp_set: assert property ($rose(status_two_out[4]) |-> $fell(status_one_out[0]))
    else $error("Suspended flag set while no CRC was running.");
  chk_resv_zero: assert property ((status_two_out & 8'he7) == 8'h00 && !status_one_out[6])
    else $error("Reserved status bit reads as one.");
  chk_nv_mask: assert property (nv_status_one_wr_out |->
    (nv_status_one_data_out & ~STATUS1_WR_MASK) == 8'h00 ##[0:1] !status_one_out[1])
    else $error("Bad stored status write.");
endmodule

bind fwp_core fwp_core_sva fwp_core_sva_i (
  .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .mem_wr_out(mem_wr_out),
  .crc_req_out(crc_req_out), .crc_suspend_out(crc_suspend_out), .crc_done_in(crc_done_in),
  .nv_status_one_wr_out(nv_status_one_wr_out), .nv_status_one_data_out(nv_status_one_data_out),
  .status_one_out(status_one_out), .status_two_out(status_two_out));

// >>> fwp_host.sv
`timescale 1ns/100ps
module fwp_host (
  // Serial link towards the device.
  output logic       sck_out,
  output logic       cs_n_out,
  output logic       si_out,
  input  wire logic  so_in,
  // Last byte shifted in.
  output logic [7:0] rx_out
);
  // Idle link: clock low, deselected.
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b1;
    rx_out = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sends whole bytes MSB first in mode 0; the clock stands still between frames.
  task automatic frame(input logic [7:0] q[$]);
    cs_n_out = 1'b0;
    #200;
    foreach (q[i]) begin
      for (int b = 7; b >= 0; b--) begin
        si_out = q[i][b];
        #200 sck_out = 1'b1;
        #190 rx_out = {rx_out[6:0], so_in};
        #10 sck_out = 1'b0;
      end
    end
    #200 cs_n_out = 1'b1;
    si_out = ~si_out; // Released data line does not keep its last value.
    #400;
  endtask
endmodule

// >>> fwp_core_test.sv
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module fwp_core_test;
  import fwp_pkg::*;
  logic         clk_sys_in = 1'b0;
  logic         nrst_in    = 1'b0;
  logic         wp_n       = 1'b1;
  logic         crc_done   = 1'b0;
  logic [7:0]   nv_img     = 8'h00;
  logic         sck, cs_n, si, so, so_oe_n, nv_wr, susp;
  logic [7:0]   nv_data, st1, st2, rx;
  fwp_mem_wr_t  mw;
  fwp_crc_req_t crc;
  int           num_errors = 0;
  int           cmp_count  = 0;
  int           n_wr       = 0;
  int           n0;
  // Rows: {bottom, code}, address, 1 if refused.
  logic [31:0]  rows [18] = '{32'h1_07e000_1, 32'h1_07dfff_0, 32'h2_07c000_1, 32'h3_077fff_0,
    32'h4_070000_1, 32'h5_05ffff_0, 32'h6_040000_1, 32'h7_000000_1, 32'h0_07ffff_0,
    32'h9_001fff_1, 32'h9_002000_0, 32'ha_003fff_1, 32'hb_008000_0, 32'hc_00ffff_1,
    32'hd_020000_0, 32'he_03ffff_1, 32'hf_07ffff_1, 32'h8_000000_0};
  logic [7:0]   clr_ops [5] = '{CMD_WR_DISABLE, CMD_SPECIAL_WRITE, CMD_SERIAL_WRITE,
    CMD_STATUS_WRITE, CMD_ANY_REG_WRITE};

  // Clock and count of accepted array bytes.
  always #25 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (mw.en === 1'b1) n_wr <= n_wr + 1;

  fwp_core fwp_core_i (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .spi_sck_in(sck), .spi_cs_n_in(cs_n),
    .spi_si_in(si), .write_protect_n_in(wp_n), .spi_so_out(so), .spi_so_oe_n_out(so_oe_n),
    .nv_status_one_in(nv_img), .nv_status_one_wr_out(nv_wr), .nv_status_one_data_out(nv_data),
    .mem_wr_out(mw), .crc_req_out(crc), .crc_suspend_out(susp), .crc_done_in(crc_done),
    .status_one_out(st1), .status_two_out(st2));
  fwp_host fwp_host_i (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so), .rx_out(rx));

  ////////////////////////////////////////////////////////////////////////////////
  // Bus helpers and the closing task.
  task automatic send(input logic [7:0] q[$]);
    fwp_host_i.frame(q);
  endtask
  task automatic wr_status(input logic [7:0] v);
    send({CMD_WR_ENABLE});
    send({CMD_STATUS_WRITE, v});
  endtask
  task automatic crc_run(input logic [7:0] e);
    send({CMD_CRC_CALC, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, e});
  endtask
  task automatic hw_reset(input logic [7:0] v);
    @(posedge clk_sys_in) #1 nrst_in = 1'b0;
    nv_img = v;
    repeat (3) @(posedge clk_sys_in);
    #1 nrst_in = 1'b1;
    repeat (6) @(posedge clk_sys_in) #1;
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Protection table, then the awkward cases.
  initial begin
    hw_reset(8'h00);
    `CHK({st1, st2}, 16'h0000)
    foreach (rows[i]) begin
      wr_status({2'b00, rows[i][31:28], 2'b00});
      `CHK(st1, {2'b00, rows[i][31:28], 2'b00})
      n0 = n_wr;
      send({CMD_WR_ENABLE});
      send({CMD_MEM_WRITE, rows[i][27:20], rows[i][19:12], rows[i][11:4], 8'h5a});
      `CHK(n_wr - n0, int'(!rows[i][0]))
      `CHK(st1[1], 1'b1)
    end
    $display("Protection table done.");
    send({CMD_WR_DISABLE});
    n0 = n_wr;
    send({CMD_MEM_WRITE, 8'h00, 8'h10, 8'h00, 8'h11});
    `CHK(n_wr - n0, 0)
    `CHK(st1[1], 1'b0)
    foreach (clr_ops[i]) begin
      send({CMD_WR_ENABLE});
      `CHK(st1[1], 1'b1)
      send({clr_ops[i], 8'h00, 8'h00, 8'h00, 8'h00});
      `CHK(st1[1], 1'b0)
    end
    wr_status(8'h80);
    @(posedge clk_sys_in) #1 wp_n = 1'b0;
    wr_status(8'h0c);
    `CHK(st1, 8'h80)
    @(posedge clk_sys_in) #1 wp_n = 1'b1;
    wr_status(8'h0c);
    `CHK(st1, 8'h0c)
    $display("Latch and lock tests done.");
    crc_run(8'h12);
    `CHK({st2, st1[0]}, 9'h010)
    send({CMD_STATUS2_READ, 8'h00});
    `CHK(rx, 8'h08)
    crc_run(8'h13);
    `CHK({st2, st1[0]}, 9'h001)
    send({CMD_WR_ENABLE});
    `CHK(st1[1], 1'b0)
    send({CMD_STATUS1_READ, 8'h00});
    `CHK(rx, 8'h0d)
    send({CMD_CRC_SUSPEND});
    `CHK({st2, st1[0], susp}, 10'h041)
    send({CMD_ANY_REG_READ, 8'h07, 8'h00, 8'h01, 8'h00});
    `CHK({rx, so_oe_n}, 9'h021)
    send({CMD_CRC_RESUME});
    `CHK({st2, st1[0]}, 9'h001)
    @(posedge clk_sys_in) #1 crc_done = 1'b1;
    @(posedge clk_sys_in) #1 crc_done = 1'b0;
    repeat (2) @(posedge clk_sys_in) #1;
    `CHK(st1[0], 1'b0)
    $display("CRC status tests done.");
    crc_run(8'h12);
    send({CMD_WR_ENABLE});
    send({CMD_RESET_ENABLE});
    send({CMD_RESET});
    `CHK({st2, st1[1:0]}, 10'h000)
    crc_run(8'h13);
    send({CMD_RESET_ENABLE});
    send({CMD_RESET});
    `CHK(st1, 8'h0c)
    crc_run(8'h13);
    send({CMD_CRC_SUSPEND});
    send({CMD_WR_ENABLE});
    hw_reset(8'hff);
    `CHK({st1, st2}, 16'hbc00)
    $display("Reset tests done.");
    conclude();
  end

  // Watchdog; the run takes about a millisecond.
  initial begin
    #3000000;
    num_errors++;
    conclude();
  end
endmodule
